// [sim/i2c_master_stop_sequencer_bench.sv]
// self-checking bench for the stop sequencer over its AHB-Lite port
// assumes one slave on the bus, so hready is the design's own hreadyout
`timescale 1ns/10ps
module i2c_master_stop_sequencer_bench import ims_pkg::*;;
   localparam int BAUD_V = 20;
   localparam int T = BAUD_V + 2;
   logic mclk, srst, hsel, hwrite, hreadyout, hresp, ninth_fall, hold_sda;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic scl_line, sda_line, scl_oe, sda_oe, irq, scl_out, sda_out;
   logic [DATA_W-1:0] tx_data;
   logic [2:0] obs;
   int errors, n_compared, k;

   ims_stop_seq ims_stop_seq_inst (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .ninth_fall(ninth_fall), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .tx_data(tx_data), .irq(irq));
   ims_bus_model ims_bus_model_inst (.scl_out(scl_out), .scl_oe(scl_oe),
      .sda_out(sda_out), .sda_oe(sda_oe),
      .hold_sda(hold_sda), .scl_line(scl_line), .sda_line(sda_line));

   // watched outputs, selected by index in the wait task
   assign obs = {irq, sda_oe, scl_oe};

   // free-running 125 MHz clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic print_verdict();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic give_up();
      errors++;
      $display("FAIL t=%0t got %h exp %h", $time, 32'h0, 32'h1);
      print_verdict();
   endtask

   // sample at the falling edge so the value equals the rising-edge sample
   task automatic wait_ready(output logic [31:0] rd);
      logic ok;
      ok = 1'b0;
      for (int i = 0; i < 16 && !ok; i++) begin
         @(negedge mclk);
         ok = (hreadyout === 1'b1);
         rd = hrdata;
         @(posedge mclk);
      end
      if (!ok)
         give_up();
   endtask

   // one single-word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      logic [31:0] junk;
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {27'h0000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      wait_ready(junk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready(rd);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] junk;
      bus(1'b1, a, d, junk);
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus(1'b0, a, 32'h00000000, v);
      check(v, exp);
   endtask

   // cycles until obs[which] reaches v; bounded so a stuck line ends the run
   task automatic wait_for(input int which, input logic v, output int n);
      n = 0;
      while (obs[which] !== v && n < 300) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 300)
         give_up();
   endtask

   task automatic s_reset();
      check({scl_oe, sda_oe, irq, hresp, scl_out, sda_out}, 32'h0);
      rd_chk(OFF_CTRL, 32'h0);
      rd_chk(OFF_STATUS, 32'h0);
      rd_chk(OFF_BAUD, {24'h000000, BAUD_RST});
      rd_chk(OFF_BUFFER, 32'h0);
      rd_chk(OFF_IRQ_STAT, 32'h0);
      rd_chk(OFF_IRQ_MASK, 32'h0);
      wr(5'h1C, 32'hFFFFFFFF);
      rd_chk(5'h1C, 32'h0);
   endtask

   // full stop with the interrupt masked, timing of the data drive and both line releases measured
   task automatic s_stop();
      wr(OFF_BAUD, BAUD_V);
      wr(OFF_BUFFER, 32'h000000A5);
      @(posedge mclk);
      ninth_fall <= 1'b1;
      @(posedge mclk);
      ninth_fall <= 1'b0;
      @(negedge mclk);
      check(scl_oe, 1'b1);
      repeat (6) @(negedge mclk);
      check({scl_oe, sda_oe}, 2'h2);
      wr(OFF_CTRL, 32'h1);
      wait_for(1, 1'b1, k);
      check(k <= 3, 1'b1);
      check(scl_oe, 1'b1);
      wait_for(0, 1'b0, k);
      check(k >= T && k <= T + 3, 1'b1);
      wait_for(1, 1'b0, k);
      check(k, T);
      repeat (T + 8) @(negedge mclk);
      check(irq, 1'b0);
      rd_chk(OFF_STATUS, 32'h1);
      rd_chk(OFF_CTRL, 32'h0);
      rd_chk(OFF_IRQ_STAT, 32'h1);
      wr(OFF_IRQ_MASK, 32'h1);
      wait_for(2, 1'b1, k);
      check(k <= 3, 1'b1);
      wr(OFF_IRQ_STAT, 32'h1);
      wait_for(2, 1'b0, k);
      check(k <= 3, 1'b1);
   endtask

   // slave holds data low; buffer write collides during the stop
   task automatic s_slow();
      wr(OFF_IRQ_MASK, 32'h3);
      @(posedge mclk);
      hold_sda <= 1'b1;
      wr(OFF_CTRL, 32'h1);
      wr(OFF_BUFFER, 32'h0000003C);
      wait_for(2, 1'b1, k);
      check(tx_data, 8'hA5);
      rd_chk(OFF_IRQ_STAT, 32'h2);
      rd_chk(OFF_BUFFER, 32'hA5);
      wr(OFF_IRQ_STAT, 32'h2);
      wait_for(2, 1'b0, k);
      wait_for(1, 1'b0, k);
      repeat (3 * T) @(negedge mclk);
      check(irq, 1'b0);
      rd_chk(OFF_STATUS, 32'h2);
      @(posedge mclk);
      hold_sda <= 1'b0;
      wait_for(2, 1'b1, k);
      check(k >= T && k <= T + 4, 1'b1);
      rd_chk(OFF_CTRL, 32'h0);
      rd_chk(OFF_IRQ_STAT, 32'h1);
      wr(OFF_IRQ_STAT, 32'h1);
   endtask

   // reset in mid-stop must release both lines and drop the enable
   task automatic s_abort();
      wr(OFF_CTRL, 32'h1);
      wait_for(1, 1'b1, k);
      @(posedge mclk);
      srst <= 1'b1;
      @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      check({scl_oe, sda_oe, irq}, 3'h0);
      check({scl_line, sda_line}, 2'h3);
      rd_chk(OFF_CTRL, 32'h0);
      rd_chk(OFF_STATUS, 32'h0);
   endtask

   // main sequence: reset held 8 cycles, then the scenarios in turn
   initial begin
      errors = 0;
      n_compared = 0;
      srst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      ninth_fall = 1'b0;
      hold_sda = 1'b0;
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      s_reset();
      s_stop();
      s_slow();
      s_abort();
      print_verdict();
   end
endmodule // i2c_master_stop_sequencer_bench

// [sim/ims_bus_model.sv]
// two-wire bus with pull-ups and one slave that may hold the data line low
// assumes the master drives both lines open-drain through output enables
`timescale 1ns/10ps
module ims_bus_model (
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic hold_sda,
   output logic scl_line,
   output logic sda_line
);
   // pull-ups: a released line reads high, never its last driven value
   assign scl_line = scl_oe ? scl_out : 1'b1;
   assign sda_line = (sda_oe ? sda_out : 1'b1) && !hold_sda; // slave stall delays stop detect
endmodule // ims_bus_model

// [verilog/ims_brg.sv]
// baud rate generator: reloadable down counter with one expiry pulse
// assumes load is a one-cycle pulse; period is reload value plus two cycles
`timescale 1ns/10ps
module ims_brg import ims_pkg::*; #(
   parameter int W = BRG_W
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic load,
   input wire logic [W-1:0] reload_val,
   output logic done,
   output logic busy
);
   logic [W-1:0] cnt;
   wire expire = busy && (cnt == '0);

   generate
      if (W < 2 || W > 16) begin : g_bad_width
         $error("ims_brg: width must be 2 to 16");
      end
   endgenerate

   // count down while active, pulse once at zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (load) begin
         cnt <= reload_val;
         busy <= 1'b1;
         done <= 1'b0;
      end else begin
         cnt <= expire ? cnt : cnt - 1'b1;
         busy <= busy && !expire;
         done <= expire;
      end
   end
endmodule // ims_brg

// [verilog/ims_irq.sv]
// sticky interrupt status with write-one-to-clear, mask and one level output
// assumes set and clear arrive as one-cycle pulses from the same clock
`timescale 1ns/10ps
module ims_irq import ims_pkg::*; #(
   parameter int N = IRQ_N
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [N-1:0] set_evt,
   input wire logic [N-1:0] clr_w1c,
   input wire logic mask_wr,
   input wire logic [N-1:0] mask_wdata,
   output logic [N-1:0] status,
   output logic [N-1:0] mask,
   output logic irq
);
   generate
      if (N < 1) begin : g_bad_n
         $error("ims_irq: need at least one source");
      end
      // a set in the clearing cycle wins so no event is lost
      for (genvar i = 0; i < N; i++) begin : g_bit
         always_ff @(posedge mclk) begin
            if (srst) begin
               status[i] <= 1'b0;
            end else begin
               status[i] <= set_evt[i] | (status[i] & ~clr_w1c[i]);
            end
         end
      end
   endgenerate

   // mask register and registered interrupt level
   always_ff @(posedge mclk) begin
      if (srst) begin
         mask <= N'(MASK_RST);
         irq <= 1'b0;
      end else begin
         mask <= mask_wr ? mask_wdata : mask;
         irq <= |(status & mask);
      end
   end
endmodule // ims_irq

// [verilog/ims_pkg.sv]
// constants, types and register map of the stop sequencer
// assumes a single 125 MHz clock domain and an AHB-Lite register port
package ims_pkg;
   // register byte offsets, low address bits only
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_STATUS = 5'h04;
   localparam logic [4:0] OFF_BAUD = 5'h08;
   localparam logic [4:0] OFF_BUFFER = 5'h0C;
   localparam logic [4:0] OFF_IRQ_STAT = 5'h10;
   localparam logic [4:0] OFF_IRQ_MASK = 5'h14;

   // field positions
   localparam int CTRL_STOP_BIT = 0;
   localparam int STAT_DET_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_WRITE_COLLISION_BIT = 1;
   localparam int IRQ_N = 2;

   // widths and reset values
   localparam int BRG_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] BAUD_RST = 8'h04;
   localparam logic [7:0] BUF_RST = 8'h00;
   localparam logic [1:0] MASK_RST = 2'h0;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // register select
   typedef enum logic [2:0] {
      REG_CTRL = 3'b000,
      REG_STATUS = 3'b001,
      REG_BAUD = 3'b010,
      REG_BUFFER = 3'b011,
      REG_IRQ_STAT = 3'b100,
      REG_IRQ_MASK = 3'b101,
      REG_NONE = 3'b111
   } ims_reg_t;

   // stop sequence states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SDA_LOW = 3'b001,
      ST_SCL_WAIT = 3'b010,
      ST_SCL_HIGH = 3'b011,
      ST_SDA_REL = 3'b100,
      ST_FINISH = 3'b101
   } ims_state_t;

   // latched ahb address phase
   typedef struct packed {
      logic valid;
      logic write;
      ims_reg_t sel;
   } ims_req_t;

   // open-drain line drive pair
   typedef struct packed {
      logic scl_oe;
      logic sda_oe;
   } ims_drv_t;
endpackage

// [verilog/ims_stop_seq.sv]
// two-wire bus stop condition sequencer with its AHB-Lite register port
// assumes open-drain pads resolved outside, byte engine pulses ninth_fall
//
// Summary of operation
// - setting stop enable starts the stop
// - hold clock low after ninth clock falls
// - first step drives data line low
// - data low seen: reload generator, count down
// - release clock, one period later release data
// - data high with clock high sets detected
// - one period later clear enable, raise interrupt
// - buffer write during stop flags collision, ignored
`timescale 1ns/10ps
module ims_stop_seq import ims_pkg::*; #(
   parameter int BW = BRG_W
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic ninth_fall,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic [DATA_W-1:0] tx_data,
   output logic irq
);
   generate
      if (BW != BRG_W) begin : g_bad_bw
         $error("ims_stop_seq: generator width must match the baud register");
      end
   endgenerate

   // map low address bits to a register
   function automatic ims_reg_t reg_decode(input logic [ADDR_W-1:0] a);
      case (a)
         OFF_CTRL: reg_decode = REG_CTRL;
         OFF_STATUS: reg_decode = REG_STATUS;
         OFF_BAUD: reg_decode = REG_BAUD;
         OFF_BUFFER: reg_decode = REG_BUFFER;
         OFF_IRQ_STAT: reg_decode = REG_IRQ_STAT;
         OFF_IRQ_MASK: reg_decode = REG_IRQ_MASK;
         default: reg_decode = REG_NONE;
      endcase
   endfunction

   ims_state_t state;
   ims_state_t next_state;
   ims_req_t req;
   ims_drv_t drv;
   ims_drv_t next_drv;
   logic stop_enable;
   logic stop_detected;
   logic [BW-1:0] baud;
   logic [DATA_W-1:0] serial_buffer;
   logic brg_done;
   logic brg_busy;
   logic [IRQ_N-1:0] irq_status;
   logic [IRQ_N-1:0] irq_mask;
   logic [31:0] next_rdata;
   logic unused_size;

   // address phase taken on hready; every answer is zero-wait OKAY
   wire addr_take = hsel && htrans[1] && hready;
   wire ims_reg_t addr_sel = reg_decode(haddr[ADDR_W-1:0]);
   wire wr_phase = req.valid && req.write;
   wire [31:0] wdata = hwdata;
   wire wr_ctrl = wr_phase && (req.sel == REG_CTRL);
   wire wr_baud = wr_phase && (req.sel == REG_BAUD);
   wire wr_buf = wr_phase && (req.sel == REG_BUFFER);
   wire wr_istat = wr_phase && (req.sel == REG_IRQ_STAT);
   wire wr_imask = wr_phase && (req.sel == REG_IRQ_MASK);
   assign unused_size = ^hsize;

   // sequence is in progress from the enable until the automatic clear
   wire seq_busy = stop_enable || (state != ST_IDLE);
   wire start_req = wr_ctrl && wdata[CTRL_STOP_BIT] && !seq_busy;
   wire write_collision_evt = wr_buf && seq_busy;
   wire buf_load = wr_buf && !seq_busy;
   wire both_high = sda_in && scl_in;
   wire det_evt = (state == ST_SDA_REL) && both_high;
   wire done_evt = (state == ST_FINISH) && brg_done;
   wire sda_seen_low = (state == ST_SDA_LOW) && !sda_in;
   wire brg_load = sda_seen_low || ((state == ST_SCL_WAIT) && brg_done)
      || det_evt;
   wire [IRQ_N-1:0] irq_set = {write_collision_evt, done_evt};
   wire [IRQ_N-1:0] irq_clr = wr_istat ? wdata[IRQ_N-1:0] : '0;
   wire [31:0] rd_status = {30'h0, seq_busy, stop_detected};
   wire [31:0] rd_istat = {{(32-IRQ_N){1'b0}}, irq_status};
   wire [31:0] rd_imask = {{(32-IRQ_N){1'b0}}, irq_mask};

   // read data chosen at the address phase, registered for the data phase
   always_comb begin
      next_rdata = WORD_ZERO;
      if (addr_take && !hwrite) begin
         case (addr_sel)
            REG_CTRL: next_rdata = {31'h0, stop_enable};
            REG_STATUS: next_rdata = rd_status;
            REG_BAUD: next_rdata = {{(32-BW){1'b0}}, baud};
            REG_BUFFER: next_rdata = {{(32-DATA_W){1'b0}}, serial_buffer};
            REG_IRQ_STAT: next_rdata = rd_istat;
            REG_IRQ_MASK: next_rdata = rd_imask;
            default: next_rdata = WORD_ZERO;
         endcase
      end
   end

   // bus slave: latch the address phase, answer with no wait state
   always_ff @(posedge mclk) begin
      if (srst) begin
         req <= '{valid: 1'b0, write: 1'b0, sel: REG_NONE};
         hrdata <= WORD_ZERO;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end else begin
         req <= '{valid: addr_take, write: hwrite, sel: addr_sel};
         hrdata <= next_rdata;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end
   end

   // software registers; hardware clear of the enable ends the sequence
   always_ff @(posedge mclk) begin
      if (srst) begin
         stop_enable <= 1'b0;
         baud <= BW'(BAUD_RST);
         serial_buffer <= BUF_RST;
      end else begin
         stop_enable <= start_req || (stop_enable && !done_evt);
         baud <= wr_baud ? wdata[BW-1:0] : baud;
         serial_buffer <= buf_load ? wdata[DATA_W-1:0] : serial_buffer;
      end
   end

   // stop seen on the bus; cleared when a new stop is requested
   always_ff @(posedge mclk) begin
      if (srst) begin
         stop_detected <= 1'b0;
      end else begin
         stop_detected <= det_evt || (stop_detected && !start_req);
      end
   end

   // sequence steps; line releases follow generator expiries
   always_comb begin
      next_state = state;
      next_drv = drv;
      case (state)
         ST_IDLE: begin
            if (ninth_fall) begin
               next_drv.scl_oe = 1'b1;
            end
            if (stop_enable) begin
               next_drv = '{scl_oe: 1'b1, sda_oe: 1'b1};
               next_state = ST_SDA_LOW;
            end
         end
         ST_SDA_LOW: begin
            if (!sda_in) begin
               next_state = ST_SCL_WAIT;
            end
         end
         ST_SCL_WAIT: begin
            if (brg_done) begin
               next_drv.scl_oe = 1'b0;
               next_state = ST_SCL_HIGH;
            end
         end
         ST_SCL_HIGH: begin
            if (brg_done) begin
               next_drv.sda_oe = 1'b0;
               next_state = ST_SDA_REL;
            end
         end
         ST_SDA_REL: begin
            if (both_high) begin
               next_state = ST_FINISH;
            end
         end
         ST_FINISH: begin
            if (brg_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_drv = '{scl_oe: 1'b0, sda_oe: 1'b0};
         end
      endcase
   end

   // state and line drive; pads only ever pull low
   always_ff @(posedge mclk) begin
      if (srst) begin
         state <= ST_IDLE;
         drv <= '{scl_oe: 1'b0, sda_oe: 1'b0};
      end else begin
         state <= next_state;
         drv <= next_drv;
      end
   end

   assign scl_oe = drv.scl_oe;
   assign sda_oe = drv.sda_oe;

   // open-drain outputs drive a constant low through their enables
   always_ff @(posedge mclk) begin
      if (srst) begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         tx_data <= BUF_RST;
      end else begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         tx_data <= serial_buffer;
      end
   end

   // one-shot reloadable period timer shared by all three waits
   ims_brg #(.W(BW)) u_brg (
      .mclk(mclk),
      .srst(srst),
      .load(brg_load),
      .reload_val(baud),
      .done(brg_done),
      .busy(brg_busy)
   );

   // completion and collision events into the interrupt
   ims_irq #(.N(IRQ_N)) u_irq (
      .mclk(mclk),
      .srst(srst),
      .set_evt(irq_set),
      .clr_w1c(irq_clr),
      .mask_wr(wr_imask),
      .mask_wdata(wdata[IRQ_N-1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

   // checks on the sequence and its registers
   property p_start;
      @(posedge mclk) disable iff (srst)
      start_req |=> stop_enable ##1 (sda_oe && scl_oe);
   endproperty
   a_start: assert property (p_start) else $error("stop did not start");

   property p_ninth;
      @(posedge mclk) disable iff (srst)
      (ninth_fall && state == ST_IDLE) |=> scl_oe;
   endproperty
   a_ninth: assert property (p_ninth) else $error("clock not held low");

   property p_scl_hold;
      @(posedge mclk) disable iff (srst)
      (state == ST_IDLE && scl_oe && !stop_enable) |=> scl_oe;
   endproperty
   a_scl_hold: assert property (p_scl_hold) else $error("clock let go before stop");

   property p_sda_first;
      @(posedge mclk) disable iff (srst)
      (state == ST_IDLE && stop_enable) |=> (state == ST_SDA_LOW) && sda_oe && scl_oe;
   endproperty
   a_sda_first: assert property (p_sda_first) else $error("data not driven low");

   property p_reload;
      @(posedge mclk) disable iff (srst)
      sda_seen_low |=> brg_busy && (state == ST_SCL_WAIT) && scl_oe;
   endproperty
   a_reload: assert property (p_reload) else $error("generator not reloaded");

   property p_scl_rel;
      @(posedge mclk) disable iff (srst)
      (state == ST_SCL_WAIT && brg_done) |=> !scl_oe && sda_oe;
   endproperty
   a_scl_rel: assert property (p_scl_rel) else $error("clock not released");

   property p_sda_hold;
      @(posedge mclk) disable iff (srst)
      (state == ST_SCL_HIGH && !brg_done) |=> sda_oe && !scl_oe && (state == ST_SCL_HIGH);
   endproperty
   a_sda_hold: assert property (p_sda_hold) else $error("data released early");

   // keyed to the step, so a reset that drops both enables is no release
   property p_sda_rel;
      @(posedge mclk) disable iff (srst)
      (state == ST_SCL_HIGH && brg_done) |=> !sda_oe && !scl_oe && (state == ST_SDA_REL);
   endproperty
   a_sda_rel: assert property (p_sda_rel) else $error("data release out of step");

   property p_sda_rel_bound;
      @(posedge mclk) disable iff (srst)
      ($fell(scl_oe) && state == ST_SCL_HIGH) |-> ##[1:300] $fell(sda_oe);
   endproperty
   a_sda_rel_bound: assert property (p_sda_rel_bound) else $error("data never released");

   property p_no_det;
      @(posedge mclk) disable iff (srst)
      (state == ST_SDA_REL && !both_high) |=> (state == ST_SDA_REL) && !stop_detected;
   endproperty
   a_no_det: assert property (p_no_det) else $error("stop flagged too soon");

   property p_det;
      @(posedge mclk) disable iff (srst)
      det_evt |=> stop_detected && (state == ST_FINISH) && brg_busy;
   endproperty
   a_det: assert property (p_det) else $error("stop not flagged");

   property p_finish;
      @(posedge mclk) disable iff (srst)
      done_evt |=> !stop_enable && irq_status[IRQ_DONE_BIT] && (state == ST_IDLE);
   endproperty
   a_finish: assert property (p_finish) else $error("sequence did not finish");

   property p_irq_out;
      @(posedge mclk) disable iff (srst)
      ((irq_status & irq_mask) != '0) |=> irq;
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");

   property p_write_collision;
      @(posedge mclk) disable iff (srst)
      write_collision_evt |=> irq_status[IRQ_WRITE_COLLISION_BIT] && $stable(serial_buffer);
   endproperty
   a_write_collision: assert property (p_write_collision) else $error("collision mishandled");

   property p_reset;
      @(posedge mclk)
      srst |=> !sda_oe && !scl_oe && !stop_enable && (state == ST_IDLE);
   endproperty
   a_reset: assert property (p_reset) else $error("reset left lines driven");
endmodule // ims_stop_seq
